// ==== common/pc_stack_pkg.sv ====
// Shared constants and types for the program-flow block
package pc_stack_pkg;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [2:0] SP_RESET = 3'h0;
    localparam logic [8:0] PORT_ADDR = 9'h000;
    localparam logic [8:0] PORT_ADDR_HI = 9'h100;
    localparam logic [7:0] PORT_READ_VALUE = 8'h00;
    // Register offsets on the AHB-Lite slave
    localparam logic [7:0] OFF_LOW_BYTE = 8'h00;
    localparam logic [7:0] OFF_LATCH = 8'h04;
    localparam logic [7:0] OFF_POINTER = 8'h08;
    localparam logic [7:0] OFF_PC_STATUS = 8'h0c;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam int CTRL_BANK_BIT = 0;
    // Core-side local addresses; kept clear of the indirect port at address zero
    localparam logic [7:0] CORE_LOW_ADDR = 8'h02;
    localparam logic [7:0] CORE_POINTER_ADDR = 8'h04;
    localparam logic [7:0] CORE_LATCH_ADDR = 8'h0a;

    typedef enum logic [2:0]
    {
        OP_NONE = 3'b000,
        OP_STEP = 3'b001,
        OP_JUMP = 3'b010,
        OP_CALL = 3'b011,
        OP_RETURN = 3'b100,
        OP_INTERRUPT = 3'b101
    } flow_op_t;

    typedef struct packed
    {
        flow_op_t op;
        logic [10:0] target;
    } flow_req_t;

    typedef struct packed
    {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } data_access_t;
endpackage

// ==== verification/data_mem_model.sv ====
// Behavioural data memory behind the indirect redirect
`timescale 1ns/1ps
module data_mem_model
(
    input wire logic clk,
    input wire logic [8:0] memAddr,
    input wire logic memRd,
    input wire logic memWr,
    input wire logic [7:0] memWdata,
    output logic [7:0] memRdata
);
    logic [7:0] mem [512];
    logic [7:0] junk = 8'h3c;
    initial for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'h5a;
    // Idle read data moves every cycle so a stale byte never passes for a real read
    assign memRdata = memRd ? mem[memAddr] : junk;
    always @(posedge clk)
    begin
        junk <= ~junk + 8'h01;
        if (memWr) mem[memAddr] <= memWdata;
    end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for program counter, return stack and indirect path
`timescale 1ns/1ps
module tb_top;
    import pc_stack_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, memRd, memWr, bank;
    logic [31:0] hrdata;
    flow_req_t flowReq = '0;
    data_access_t coreAccess = '0;
    logic [12:0] pc, pcm;
    logic [12:0] stk [8];
    logic [8:0] memAddr, ea;
    logic [7:0] memWdata, memRdata, coreRdata, latch, ptr, lo;
    logic [2:0] sp;
    logic [10:0] t;
    int fail_count = 0;
    int n_tests = 0;
    integer seed = 32'hf009dc24;
    logic [31:0] expQ [$];
    string nameQ [$];
    logic rdPhase = 1'h0;
    logic pcCheck = 1'h0;

    always #12.5 clk = ~clk;

    program_counter_stack_indirect u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .flowReq(flowReq), .coreAccess(coreAccess), .vectorAddr(8'h40), .pc(pc),
        .memAddr(memAddr), .memRd(memRd), .memWr(memWr), .memWdata(memWdata),
        .memRdata(memRdata), .coreRdata(coreRdata));
    data_mem_model u_mem (.clk(clk), .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
        .memWdata(memWdata), .memRdata(memRdata));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] seen);
        logic [31:0] e;
        string n;
        e = expQ.pop_front();
        n = nameQ.pop_front();
        n_tests++;
        if (seen !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'h1);
    endtask

    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        nameQ.push_back(n);
        bus(1'h0, a, 32'h0);
    endtask

    // The counter is watched on its own port: software has no read path to its top bits
    task automatic chk_pc(input string n, input logic [12:0] e);
        expQ.push_back({19'h0, e});
        nameQ.push_back(n);
        @(posedge clk);
        pcCheck <= 1'h1;
        @(posedge clk);
        pcCheck <= 1'h0;
    endtask

    task automatic flow(input flow_op_t op, input logic [10:0] tg);
        @(posedge clk);
        flowReq <= '{op, tg};
        @(posedge clk);
        flowReq <= '0;
    endtask

    task automatic call_ret(input logic c);
        t = 11'($random(seed));
        if (c)
        begin
            stk[sp] = pcm + 13'h1;
            sp = sp + 3'h1;
            pcm = {latch[4:3], t};
            flow(OP_CALL, t);
        end
        else
        begin
            sp = sp - 3'h1;
            pcm = stk[sp];
            flow(OP_RETURN, 11'h0);
        end
        chk_pc("pc stack", pcm);
    endtask

    task automatic core(input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        coreAccess <= '{r, ~r, a, d};
        @(posedge clk);
        coreAccess <= '0;
    endtask

    // Read data is judged at the edge that closes its data phase
    always @(posedge clk)
    begin
        if (rdPhase) cmp(hrdata);
        if (coreAccess.rd) cmp({24'h0, coreRdata});
        if (pcCheck) cmp({19'h0, pc});
        rdPhase <= hsel && htrans[1] && hreadyout && !hwrite;
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        chk_pc("pc", PC_RESET);
        rd("latch", OFF_LATCH, 32'h0);
        $display("test reset done");
        latch = 8'($random(seed)) & 8'h1f;
        lo = 8'($random(seed));
        bus(1'h1, OFF_LATCH, {24'h0, latch});
        bus(1'h1, OFF_LOW_BYTE, {24'h0, lo});
        pcm = {latch[4:0], lo};
        chk_pc("pc", pcm);
        rd("low byte", OFF_LOW_BYTE, {24'h0, lo});
        rd("pc hidden", OFF_PC_STATUS, 32'h0);
        t = 11'($random(seed));
        pcm = {latch[4:3], t};
        flow(OP_JUMP, t);
        chk_pc("pc jump", pcm);
        flow(OP_STEP, 11'h0);
        pcm = pcm + 13'h1;
        chk_pc("pc step", pcm);
        // Computed jump across a page: software carries into the latch itself
        latch = latch + 8'h01;
        core(1'h0, CORE_LATCH_ADDR, latch);
        core(1'h0, CORE_LOW_ADDR, 8'h00);
        pcm = {latch[4:0], 8'h00};
        chk_pc("pc rollover", pcm);
        $display("test pc load done");
        sp = SP_RESET;
        repeat (9) call_ret(1'h1);
        repeat (9) call_ret(1'h0);
        stk[sp] = pcm + 13'h1;
        sp = sp + 3'h1;
        pcm = {5'h00, 8'h40};
        flow(OP_INTERRUPT, 11'h0);
        chk_pc("pc vector", pcm);
        call_ret(1'h0);
        t = 11'($random(seed));
        @(posedge clk);
        flowReq <= '{OP_CALL, t};
        @(posedge clk);
        flowReq <= '{OP_RETURN, 11'h0};
        @(posedge clk);
        flowReq <= '0;
        stk[sp] = pcm + 13'h1;
        pcm = pcm + 13'h1;
        chk_pc("pc call return", pcm);
        rd("latch", OFF_LATCH, {24'h0, latch});
        $display("test stack done");
        rst_n <= 1'h0;
        @(posedge clk);
        rst_n <= 1'h1;
        sp = SP_RESET;
        latch = LATCH_RESET;
        chk_pc("pc mid reset", PC_RESET);
        rd("latch mid reset", OFF_LATCH, {24'h0, LATCH_RESET});
        $display("test mid reset done");
        for (int i = 0; i < 4; i++)
        begin
            bank = i[0];
            ptr = (i < 2) ? 8'h00 : (8'($random(seed)) | 8'h01);
            ea = {bank, ptr};
            lo = 8'($random(seed));
            bus(1'h1, OFF_CTRL, {31'h0, bank});
            if (i[0]) core(1'h0, CORE_POINTER_ADDR, ptr);
            else bus(1'h1, OFF_POINTER, {24'h0, ptr});
            core(1'h0, PORT_ADDR[7:0], lo);
            expQ.push_back((i < 2) ? 32'h0 : {24'h0, lo});
            nameQ.push_back("core data");
            core(1'h1, PORT_ADDR[7:0], 8'h00);
            // Let the watcher take the core read first so the queue stays in order
            @(negedge clk);
            expQ.push_back({24'h0, (i < 2) ? 8'h5a : lo});
            nameQ.push_back("memory");
            cmp({24'h0, u_mem.mem[ea]});
        end
        $display("test indirect done");
        tally_and_finish;
    end

    initial
    begin
        #100000;
        fail_count++;
        tally_and_finish;
    end
endmodule

// ==== verilog/program_counter_stack_indirect.sv ====
// Program counter, circular return stack and indirect addressing with an AHB-Lite slave
// What this block does
// (RQ1) 13-bit program counter; low byte accessible, upper bits only from latch.
// (RQ2) Any reset clears the whole program counter.
// (RQ3) Writing the low byte loads bits 12..8 from latch bits 4..0 together.
// (RQ4) Call or direct jump takes top two counter bits from latch bits 4..3.
// (RQ5) Software increments the latch itself on computed-jump rollover; no carry here.
// (RQ6) Eight 13-bit return entries, pointer hidden from software.
// (RQ7) Calls and interrupt vectoring push the program counter.
// (RQ8) Return, return-with-literal and return-from-interrupt pop into the counter.
// (RQ9) Pushes and pops never change the high latch.
// (RQ10) Stack is circular; ninth push overwrites first entry.
// (RQ11) No overflow or underflow indication exists.
// (RQ12) Indirect port has no storage; accesses go to pointer-selected location.
// (RQ13) Indirect read of the port itself returns zero.
// (RQ14) Indirect write to the port itself is discarded.
// (RQ15) Effective indirect address is bank bit above 8-bit pointer.
// (RQ16) Pop decrements pointer modulo eight; stale entries return on underflow.
`timescale 1ns/1ps
module program_counter_stack_indirect
    import pc_stack_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Execution core
    input wire flow_req_t flowReq,
    input wire data_access_t coreAccess,
    input wire logic [7:0] vectorAddr,
    output logic [12:0] pc,
    output logic [8:0] memAddr,
    output logic memRd,
    output logic memWr,
    output logic [7:0] memWdata,
    input wire logic [7:0] memRdata,
    output logic [7:0] coreRdata
);

    logic [12:0] stack [STACK_DEPTH];
    logic [2:0] sp;
    logic [7:0] latch;
    logic [7:0] pointer;
    logic bankBit;

    // AHB address phase capture
    logic apValid;
    logic apWrite;
    logic [7:0] apAddr;
    logic busWrLow;
    logic busWrLatch;
    logic busWrPointer;
    logic busWrCtrl;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            apValid <= 1'b0;
            apWrite <= 1'b0;
            apAddr <= 8'h00;
        end
        else if (hready)
        begin
            apValid <= hsel && htrans[1];
            apWrite <= hwrite;
            apAddr <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb
    begin
        busWrLow = 1'b0;
        busWrLatch = 1'b0;
        busWrPointer = 1'b0;
        busWrCtrl = 1'b0;
        if (apValid && apWrite)
        begin
            if (apAddr == OFF_LOW_BYTE)
                busWrLow = 1'b1;
            else if (apAddr == OFF_LATCH)
                busWrLatch = 1'b1;
            else if (apAddr == OFF_POINTER)
                busWrPointer = 1'b1;
            else if (apAddr == OFF_CTRL)
                busWrCtrl = 1'b1;
        end
    end

    // Read data is combinational from registers so it stands in the data phase
    // Counter bits 12..8 have no read path at all [RQ1]
    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (apValid && !apWrite)
        begin
            if (apAddr == OFF_LOW_BYTE)
                hrdata = {24'h000000, pc[7:0]}; // [RQ1]
            else if (apAddr == OFF_LATCH)
                hrdata = {24'h000000, latch};
            else if (apAddr == OFF_POINTER)
                hrdata = {24'h000000, pointer};
            else if (apAddr == OFF_CTRL)
                hrdata = {31'h00000000, bankBit};
        end
    end

    // Indirect resolution: a core access to the port address is redirected
    logic [8:0] effAddr;
    logic coreLowWr;
    logic coreLatchWr;
    logic corePointerWr;
    logic targetsPort;

    assign effAddr = {bankBit, pointer}; // [RQ15]
    assign targetsPort = (effAddr == PORT_ADDR) || (effAddr == PORT_ADDR_HI);

    always_comb
    begin
        memAddr = {1'b0, coreAccess.addr};
        memRd = coreAccess.rd;
        memWr = coreAccess.wr;
        memWdata = coreAccess.wdata;
        coreRdata = memRdata;
        if (coreAccess.addr == PORT_ADDR[7:0])
        begin
            memAddr = effAddr; // [RQ12]
            if (targetsPort)
            begin
                memRd = 1'b0;
                memWr = 1'b0; // [RQ14]
                coreRdata = PORT_READ_VALUE; // [RQ13]
            end
        end
    end

    // Only direct writes to the local registers count; an indirect hit is the memory's
    assign coreLowWr = coreAccess.wr && coreAccess.addr == CORE_LOW_ADDR;
    assign coreLatchWr = coreAccess.wr && coreAccess.addr == CORE_LATCH_ADDR;
    assign corePointerWr = coreAccess.wr && coreAccess.addr == CORE_POINTER_ADDR;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            latch <= LATCH_RESET;
        else if (busWrLatch)
            latch <= hwdata[7:0];
        else if (coreLatchWr)
            latch <= coreAccess.wdata; // Push and pop never touch this [RQ9]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pointer <= POINTER_RESET;
        else if (busWrPointer)
            pointer <= hwdata[7:0];
        else if (corePointerWr)
            pointer <= coreAccess.wdata;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            bankBit <= 1'b0;
        else if (busWrCtrl)
            bankBit <= hwdata[CTRL_BANK_BIT];
    end

    // Program counter; low-byte write outranks flow ops in the same cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pc <= PC_RESET; // [RQ2]
        else if (busWrLow)
            pc <= {latch[4:0], hwdata[7:0]}; // [RQ3]
        else if (coreLowWr)
            pc <= {latch[4:0], coreAccess.wdata}; // [RQ3] [RQ1]
        else
        begin
            case (flowReq.op)
                OP_STEP: pc <= pc + 13'h0001;
                OP_JUMP, OP_CALL: pc <= {latch[4:3], flowReq.target}; // [RQ4]
                OP_RETURN: pc <= stack[sp - 3'h1]; // [RQ8]
                OP_INTERRUPT: pc <= {5'h00, vectorAddr};
                default: pc <= pc;
            endcase
        end
    end

    // Stack pointer wraps freely: no overflow or underflow flag exists [RQ11]
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sp <= SP_RESET;
        else if (!busWrLow && !coreLowWr)
        begin
            if (flowReq.op == OP_CALL || flowReq.op == OP_INTERRUPT)
                sp <= sp + 3'h1; // [RQ10]
            else if (flowReq.op == OP_RETURN)
                sp <= sp - 3'h1; // [RQ16]
        end
    end

    // Return address is the next instruction; no reset keeps the array as plain storage
    always_ff @(posedge clk)
    begin
        if (rst_n && !busWrLow && !coreLowWr
            && (flowReq.op == OP_CALL || flowReq.op == OP_INTERRUPT))
            stack[sp] <= pc + 13'h0001; // [RQ7] [RQ6]
    end

    property p_low_write;
        @(posedge clk) disable iff (!rst_n)
        busWrLow |=> pc == {$past(latch[4:0]), $past(hwdata[7:0])};
    endproperty
    a_low_write: assert property (p_low_write) else $error("low byte write load wrong"); // [RQ3]

    property p_jump;
        @(posedge clk) disable iff (!rst_n)
        (!busWrLow && !coreLowWr && flowReq.op == OP_JUMP)
        |=> pc[12:11] == $past(latch[4:3]);
    endproperty
    a_jump: assert property (p_jump) else $error("jump upper bits wrong"); // [RQ4]

    property p_call_return;
        @(posedge clk) disable iff (!rst_n)
        (!busWrLow && !coreLowWr && flowReq.op == OP_CALL)
        ##1 (!busWrLow && !coreLowWr && flowReq.op == OP_RETURN)
        |=> pc == $past(pc, 2) + 13'h0001;
    endproperty
    a_call_return: assert property (p_call_return) else $error("return address lost"); // [RQ8]

    property p_latch_kept;
        @(posedge clk) disable iff (!rst_n)
        (flowReq.op inside {OP_CALL, OP_RETURN, OP_INTERRUPT} && !busWrLatch && !coreLatchWr)
        |=> $stable(latch);
    endproperty
    a_latch_kept: assert property (p_latch_kept) else $error("latch changed by stack"); // [RQ9]

    property p_sp_wrap;
        @(posedge clk) disable iff (!rst_n)
        (!busWrLow && !coreLowWr && flowReq.op inside {OP_CALL, OP_INTERRUPT})
        |=> sp == $past(sp) + 3'h1;
    endproperty
    a_sp_wrap: assert property (p_sp_wrap) else $error("push pointer step wrong"); // [RQ10]

    property p_sp_pop;
        @(posedge clk) disable iff (!rst_n)
        (!busWrLow && !coreLowWr && flowReq.op == OP_RETURN) |=> sp == $past(sp) - 3'h1;
    endproperty
    a_sp_pop: assert property (p_sp_pop) else $error("pop pointer step wrong"); // [RQ16]

    property p_port_read;
        @(posedge clk) disable iff (!rst_n)
        (coreAccess.addr == PORT_ADDR[7:0] && targetsPort) |-> coreRdata == 8'h00 && !memWr;
    endproperty
    a_port_read: assert property (p_port_read) else $error("self indirect not zero"); // [RQ13]

    property p_eff_addr;
        @(posedge clk) disable iff (!rst_n)
        (coreAccess.addr == PORT_ADDR[7:0] && !targetsPort) |-> memAddr == {bankBit, pointer};
    endproperty
    a_eff_addr: assert property (p_eff_addr) else $error("indirect address wrong"); // [RQ15]

    property p_reset_pc;
        @(posedge clk) $rose(rst_n) |-> pc == 13'h0000;
    endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("pc not cleared"); // [RQ2]

    property p_core_low;
        @(posedge clk) disable iff (!rst_n)
        (coreLowWr && !busWrLow) |=> pc == {$past(latch[4:0]), $past(coreAccess.wdata)};
    endproperty
    a_core_low: assert property (p_core_low) else $error("core low load wrong"); // [RQ3]

    property p_port_write;
        @(posedge clk) disable iff (!rst_n)
        (coreAccess.addr == PORT_ADDR[7:0] && targetsPort) |-> !memWr && !memRd;
    endproperty
    a_port_write: assert property (p_port_write) else $error("self write kept"); // [RQ14]

    property p_int_push;
        @(posedge clk) disable iff (!rst_n)
        (!busWrLow && !coreLowWr && flowReq.op == OP_INTERRUPT)
        |=> stack[$past(sp)] == $past(pc) + 13'h0001 && pc == {5'h00, $past(vectorAddr)};
    endproperty
    a_int_push: assert property (p_int_push) else $error("interrupt push wrong"); // [RQ7]

    c_call: cover property (@(posedge clk) disable iff (!rst_n) flowReq.op == OP_CALL);
    c_wrap: cover property (@(posedge clk) disable iff (!rst_n) sp == 3'h7 ##1 sp == 3'h0);
    c_port: cover property (@(posedge clk) disable iff (!rst_n)
        coreAccess.addr == PORT_ADDR[7:0] && targetsPort);
endmodule
